// file: design/timer_pkg.sv
// constants for the 8-bit timer waveform and compare-output block
// assumes a 32-bit AXI4-Lite master and one 25 MHz clock
package timer_pkg;
	localparam int ADDR_W = 5;
	// register byte addresses
	localparam logic [4:0] CTRL_OFS = 5'h00;
	localparam logic [4:0] COUNT_OFS = 5'h04;
	localparam logic [4:0] COMPARE_OFS = 5'h08;
	localparam logic [4:0] STATUS_OFS = 5'h0C;
	localparam logic [4:0] PIN_OFS = 5'h10;
	// control register fields
	localparam int WGM_LO = 0;
	localparam int COM_LO = 2;
	localparam int CS_LO = 4;
	localparam int FOC_BIT = 7;
	// status and pin register fields
	localparam int OVF_BIT = 0;
	localparam int OCF_BIT = 1;
	localparam int DDR_BIT = 0;
	localparam int PORT_BIT = 1;
	localparam int OCS_BIT = 2;
	// waveform modes
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_PHASE = 2'h1;
	localparam logic [1:0] MODE_CTC = 2'h2;
	localparam logic [1:0] MODE_FAST = 2'h3;
	// compare output actions
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] REG_RST = 8'h00;
	// last prescaler count per clock select: stop,1,8,32,64,128,256,1024
	localparam logic [9:0] PRESC_LAST [8] = '{10'h000, 10'h000, 10'h007,
		10'h01F, 10'h03F, 10'h07F, 10'h0FF, 10'h3FF};
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : timer_pkg

// file: design/timer_waveform_output_modes.sv
// 8-bit timer with normal, clear-on-match and fast pwm counting,
// compare-output state and port override, behind an AXI4-Lite slave.
// assumes srst_i synchronous to mclk_i; pin wire resolved outside.
// Function
// - nonzero output mode overrides port output value
// - waveform shows on pin only when direction=output
// - override depends only on output mode field
// - output state preset before pin enabled
// - output mode zero leaves state untouched
// - mode change acts at next match; force immediate
// - waveform mode alone sets counting sequence
// - normal mode counts up, wraps FF to 00
// - normal overflow flag sets as count hits zero
// - normal mode accepts counter writes anytime
// - mode 2 clears counter on compare match
// - mode 2 sets compare flag at top
// - mode 2 compare writes unbuffered, may wrap first
// - mode 2 toggle output on each match
// - prescale 1,8,32,64,128,256,1024 divides timer clock
// - mode 2 overflow flag sets stepping max to 00
// - fast pwm counts zero to max, restarts
// - fast non-inverting: clear on match, set bottom
// - fast inverting: set on match, clear bottom
// - fast pwm clears counter tick after max
// - force updates state only, no flag or clear
// - match sets compare flag next timer cycle
// - pwm compare writes buffered, loaded at top
// - fast pwm overflow flag sets at max
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module timer_waveform_output_modes (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic [timer_pkg::ADDR_W-1:0] s_awaddr_i,
	input wire logic s_awvalid_i,
	output logic s_awready_o,
	input wire logic [31:0] s_wdata_i,
	input wire logic [3:0] s_wstrb_i,
	input wire logic s_wvalid_i,
	output logic s_wready_o,
	output logic [1:0] s_bresp_o,
	output logic s_bvalid_o,
	input wire logic s_bready_i,
	input wire logic [timer_pkg::ADDR_W-1:0] s_araddr_i,
	input wire logic s_arvalid_i,
	output logic s_arready_o,
	output logic [31:0] s_rdata_o,
	output logic [1:0] s_rresp_o,
	output logic s_rvalid_o,
	input wire logic s_rready_i,
	output logic pin_o,
	output logic pin_oe_o
);
	import timer_pkg::*;

	initial begin
		if (ADDR_W < 5) begin
			$error("address width too small for register map");
		end
	end

	function automatic logic oc_action(input logic [1:0] com, input logic oc);
		case (com)
			COM_TOGGLE: oc_action = ~oc;
			COM_CLEAR: oc_action = 1'b0;
			COM_SET: oc_action = 1'b1;
			default: oc_action = oc;
		endcase
	endfunction : oc_action

	// bus state
	logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
	logic arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [7:0] wdata_q, wdata_d;
	logic wstrb_q, wstrb_d;
	// timer state
	logic [1:0] wgm_q, wgm_d, com_q, com_d;
	logic [2:0] cs_q, cs_d;
	logic [9:0] presc_q, presc_d;
	logic [7:0] cnt_q, cnt_d, ocr_q, ocr_d, ocr_buf_q, ocr_buf_d;
	logic blk_q, blk_d, oc_q, oc_d, ovf_q, ovf_d, ocf_q, ocf_d;
	logic ddr_q, ddr_d, port_q, port_d, pin_q, pin_d, oe_q, oe_d;

	logic wr_fire, wr_hit, wr_ctrl, wr_cnt, wr_cmp, wr_sts, wr_pin;
	logic tick, match, hit, at_max, pwm, force_now;

	// both address and data held, response not yet raised
	assign wr_fire = !awready_q && !wready_q && !bvalid_q;
	assign wr_hit = awaddr_q == CTRL_OFS || awaddr_q == COUNT_OFS ||
		awaddr_q == COMPARE_OFS || awaddr_q == STATUS_OFS ||
		awaddr_q == PIN_OFS;
	assign wr_ctrl = wr_fire && wstrb_q && awaddr_q == CTRL_OFS;
	assign wr_cnt = wr_fire && wstrb_q && awaddr_q == COUNT_OFS;
	assign wr_cmp = wr_fire && wstrb_q && awaddr_q == COMPARE_OFS;
	assign wr_sts = wr_fire && wstrb_q && awaddr_q == STATUS_OFS;
	assign wr_pin = wr_fire && wstrb_q && awaddr_q == PIN_OFS;

	always_comb begin
		awready_d = awready_q;
		wready_d = wready_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		if (s_awvalid_i && awready_q) begin
			awready_d = 1'b0;
			awaddr_d = s_awaddr_i;
		end
		if (s_wvalid_i && wready_q) begin
			wready_d = 1'b0;
			wdata_d = s_wdata_i[7:0];
			wstrb_d = s_wstrb_i[0];
		end
		if (wr_fire) begin
			bvalid_d = 1'b1;
			bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_q && s_bready_i) begin
			bvalid_d = 1'b0;
			awready_d = 1'b1;
			wready_d = 1'b1;
		end
		if (s_arvalid_i && arready_q) begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = 32'h00000000;
			case (s_araddr_i)
				// force strobe always reads as zero
				CTRL_OFS: rdata_d[6:0] = {cs_q, com_q, wgm_q};
				COUNT_OFS: rdata_d[7:0] = cnt_q;
				// pwm modes expose the buffer, not the active compare
				COMPARE_OFS: rdata_d[7:0] = ocr_buf_q;
				STATUS_OFS: rdata_d[1:0] = {ocf_q, ovf_q};
				PIN_OFS: rdata_d[2:0] = {oc_q, port_q, ddr_q};
				default: rresp_d = RESP_SLVERR;
			endcase
		end
		if (rvalid_q && s_rready_i) begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h00000000;
			awaddr_q <= '0;
			wdata_q <= REG_RST;
			wstrb_q <= 1'b0;
		end else begin
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
		end
	end

	// >= so a clock select change mid-period cannot stall the prescaler
	assign tick = cs_q != 3'h0 && presc_q >= PRESC_LAST[cs_q];
	assign match = cnt_q == ocr_q;
	assign hit = tick && match && !blk_q;
	assign at_max = cnt_q == CNT_MAX;
	assign pwm = wgm_q[0];
	// force only counts when the newly written mode is non-pwm
	assign force_now = wr_ctrl && wdata_q[FOC_BIT] && !wdata_q[WGM_LO];

	always_comb begin
		wgm_d = wgm_q;
		com_d = com_q;
		cs_d = cs_q;
		presc_d = (tick || cs_q == 3'h0) ? 10'h000 : presc_q + 10'h001;
		cnt_d = cnt_q;
		ocr_d = ocr_q;
		ocr_buf_d = ocr_buf_q;
		blk_d = blk_q;
		oc_d = oc_q;
		ddr_d = ddr_q;
		port_d = port_q;
		ovf_d = ovf_q;
		ocf_d = ocf_q;
		if (tick) begin
			blk_d = 1'b0;
			if (hit) begin
				ocf_d = 1'b1;
			end
			if (at_max) begin
				ovf_d = 1'b1;
			end
			// sequence depends on waveform mode only
			if (wgm_q == MODE_CTC && hit) begin
				cnt_d = CNT_BOTTOM;
			end else begin
				cnt_d = cnt_q + 8'h01;
			end
			if (pwm && at_max) begin
				ocr_d = ocr_buf_q;
			end
			// com zero leaves the state alone
			if (hit) begin
				oc_d = oc_action(com_q, oc_q);
			end
			// bottom action after match so max compare gives a flat line
			if (pwm && at_max && com_q[1]) begin
				oc_d = com_q == COM_CLEAR;
			end
		end
		if (force_now) begin
			// written mode bits decide the forced action
			oc_d = oc_action(wdata_q[COM_LO+1:COM_LO], oc_q);
		end
		if (wr_ctrl) begin
			wgm_d = wdata_q[WGM_LO+1:WGM_LO];
			com_d = wdata_q[COM_LO+1:COM_LO];
			cs_d = wdata_q[CS_LO+2:CS_LO];
		end
		if (wr_cnt) begin
			// bus write beats counting and blocks the next match
			cnt_d = wdata_q;
			blk_d = 1'b1;
		end
		if (wr_cmp) begin
			ocr_buf_d = wdata_q;
			if (!pwm) begin
				ocr_d = wdata_q;
			end
		end
		if (wr_pin) begin
			ddr_d = wdata_q[DDR_BIT];
			port_d = wdata_q[PORT_BIT];
		end
		// write-one-to-clear, a same-cycle set wins
		if (wr_sts && wdata_q[OVF_BIT] && !(tick && at_max)) begin
			ovf_d = 1'b0;
		end
		if (wr_sts && wdata_q[OCF_BIT] && !hit) begin
			ocf_d = 1'b0;
		end
		pin_d = com_q != COM_OFF ? oc_q : port_q;
		oe_d = ddr_q;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			wgm_q <= MODE_NORMAL;
			com_q <= COM_OFF;
			oc_q <= 1'b0;
			cs_q <= 3'h0;
			presc_q <= 10'h000;
			cnt_q <= REG_RST;
			ocr_q <= REG_RST;
			ocr_buf_q <= REG_RST;
			blk_q <= 1'b0;
			ddr_q <= 1'b0;
			port_q <= 1'b0;
			ovf_q <= 1'b0;
			ocf_q <= 1'b0;
			pin_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			wgm_q <= wgm_d;
			com_q <= com_d;
			oc_q <= oc_d;
			cs_q <= cs_d;
			presc_q <= presc_d;
			cnt_q <= cnt_d;
			ocr_q <= ocr_d;
			ocr_buf_q <= ocr_buf_d;
			blk_q <= blk_d;
			ddr_q <= ddr_d;
			port_q <= port_d;
			ovf_q <= ovf_d;
			ocf_q <= ocf_d;
			pin_q <= pin_d;
			oe_q <= oe_d;
		end
	end

	assign s_awready_o = awready_q;
	assign s_wready_o = wready_q;
	assign s_bvalid_o = bvalid_q;
	assign s_bresp_o = bresp_q;
	assign s_arready_o = arready_q;
	assign s_rvalid_o = rvalid_q;
	assign s_rresp_o = rresp_q;
	assign s_rdata_o = rdata_q;
	assign pin_o = pin_q;
	assign pin_oe_o = oe_q;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	sequence s_quiet_tick;
		tick && !wr_cnt && !wr_ctrl;
	endsequence
	sequence s_fast_max;
		s_quiet_tick ##0 wgm_q == MODE_FAST && at_max;
	endsequence

	AST_PIN_SOURCE: assert property (
		##1 pin_o == ($past(com_q) != COM_OFF ? $past(oc_q) : $past(port_q)))
		else $error("pin output source wrong");
	AST_PIN_DIR: assert property (
		(ddr_q && !wr_pin) |=> ##1 pin_oe_o)
		else $error("pin not driven with direction output");
	AST_COM_OFF_HOLD: assert property (
		(com_q == COM_OFF && !force_now) |=> $stable(oc_q))
		else $error("output state moved with output mode zero");
	AST_NORMAL_WRAP: assert property (
		(s_quiet_tick ##0 wgm_q == MODE_NORMAL && at_max)
		|=> cnt_q == CNT_BOTTOM && ovf_q)
		else $error("normal mode wrap or overflow flag wrong");
	AST_CTC_CLEAR: assert property (
		(s_quiet_tick ##0 wgm_q == MODE_CTC && hit && !wr_sts)
		|=> cnt_q == CNT_BOTTOM && ocf_q)
		else $error("clear-on-match did not clear and flag");
	AST_FAST_RESTART: assert property (
		s_fast_max |=> cnt_q == CNT_BOTTOM && ovf_q)
		else $error("fast pwm did not restart after max");
	AST_FAST_BOTTOM: assert property (
		(s_fast_max ##0 com_q == COM_CLEAR) |=> oc_q ##1 pin_o)
		else $error("non-inverting output not set at bottom");
	AST_FORCE_NO_FLAG: assert property (
		(force_now && !tick && !wr_sts) |=> $stable(ocf_q) && $stable(cnt_q))
		else $error("force touched flag or counter");
	AST_MATCH_FLAG: assert property (
		(hit && !wr_sts) |=> ocf_q)
		else $error("compare flag not set after match");
	AST_PWM_BUFFER: assert property (
		(wr_cmp && pwm && !(tick && at_max)) |=> ocr_q == $past(ocr_q))
		else $error("pwm compare write bypassed the buffer");
endmodule : timer_waveform_output_modes

// file: bench/pin_load.sv
// external load on the compare pin: resolves the pin level
// and measures the length of its high and low runs in clocks
// assumes pin_o and pin_oe_o come from the timer, sampled on mclk_i
`timescale 1ns/1ps
module pin_load (
	input wire logic mclk_i,
	input wire logic pin_o,
	input wire logic pin_oe_o,
	output logic level_o,
	output int hi_len_o,
	output int lo_len_o
);
	logic last_q = 1'b0;
	logic prev_q = 1'b0;
	int run = 0;
	int hi_q = 0;
	int lo_q = 0;
	// undriven pin has no pull: show the inverse of the last driven level
	assign level_o = pin_oe_o ? pin_o : ~last_q;
	assign hi_len_o = hi_q;
	assign lo_len_o = lo_q;
	always @(posedge mclk_i) begin
		if (pin_oe_o)
			last_q <= pin_o;
		if (level_o === prev_q)
			run <= run + 1;
		else begin
			if (prev_q)
				hi_q <= run;
			else
				lo_q <= run;
			run <= 1;
		end
		prev_q <= level_o;
	end
endmodule : pin_load

// file: bench/test_timer_waveform_output_modes.sv
// self-checking bench for the timer waveform block
// assumes an AXI4-Lite slave; only the watchdog ends a bus wait
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
	miscompares++; $display("BAD %0t got %0h exp %0h", $time, g, e); \
	end end
module test_timer_waveform_output_modes;
	import timer_pkg::*;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [4:0] s_awaddr_i = '0, s_araddr_i = '0;
	logic s_awvalid_i = 1'b0, s_wvalid_i = 1'b0, s_bready_i = 1'b0;
	logic s_arvalid_i = 1'b0, s_rready_i = 1'b0;
	logic [31:0] s_wdata_i = '0;
	logic [3:0] s_wstrb_i = 4'h1;
	logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
	logic [1:0] s_bresp_o, s_rresp_o, resp;
	logic [31:0] s_rdata_o, rdat;
	logic pin_o, pin_oe_o, level;
	int hi_len, lo_len, miscompares = 0, n_compared = 0;
	int seed = 1284, c, hp;
	int nfac [4] = '{1, 1, 8, 32};
	logic [4:0] offs [4] = '{CTRL_OFS, COUNT_OFS, STATUS_OFS, PIN_OFS};
	always #20 mclk_i = ~mclk_i;
	timer_waveform_output_modes u_timer_waveform_output_modes (
		.mclk_i(mclk_i), .srst_i(srst_i),
		.s_awaddr_i(s_awaddr_i), .s_awvalid_i(s_awvalid_i),
		.s_awready_o(s_awready_o), .s_wdata_i(s_wdata_i),
		.s_wstrb_i(s_wstrb_i), .s_wvalid_i(s_wvalid_i),
		.s_wready_o(s_wready_o), .s_bresp_o(s_bresp_o),
		.s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i),
		.s_araddr_i(s_araddr_i), .s_arvalid_i(s_arvalid_i),
		.s_arready_o(s_arready_o), .s_rdata_o(s_rdata_o),
		.s_rresp_o(s_rresp_o), .s_rvalid_o(s_rvalid_o),
		.s_rready_i(s_rready_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
	pin_load u_pin_load (.mclk_i(mclk_i), .pin_o(pin_o),
		.pin_oe_o(pin_oe_o), .level_o(level), .hi_len_o(hi_len),
		.lo_len_o(lo_len));
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		s_awaddr_i <= a;
		s_wdata_i <= {24'h0, d};
		s_awvalid_i <= 1'b1;
		s_wvalid_i <= 1'b1;
		s_bready_i <= 1'b1;
		do begin
			@(posedge mclk_i);
			if (s_awready_o) s_awvalid_i <= 1'b0;
			if (s_wready_o) s_wvalid_i <= 1'b0;
		end while (s_bvalid_o !== 1'b1);
		resp = s_bresp_o;
		s_bready_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a);
		@(posedge mclk_i);
		s_araddr_i <= a;
		s_arvalid_i <= 1'b1;
		s_rready_i <= 1'b1;
		do begin
			@(posedge mclk_i);
			if (s_arready_o) s_arvalid_i <= 1'b0;
		end while (s_rvalid_o !== 1'b1);
		rdat = s_rdata_o;
		resp = s_rresp_o;
		s_rready_i <= 1'b0;
	endtask : rd
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (30000) @(posedge mclk_i);
		miscompares++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		srst_i <= 1'b0;
		foreach (offs[i]) begin
			rd(offs[i]);
			`CHK(rdat, 32'h0)
		end
		rd(5'h14);
		`CHK(resp, RESP_SLVERR)
		wr(5'h14, 8'h01);
		`CHK(resp, RESP_SLVERR)
		$display("test reset done");
		// preset the state by force before the pin is enabled
		wr(CTRL_OFS, 8'h8C);
		rd(STATUS_OFS);
		`CHK(rdat, 32'h0)
		rd(PIN_OFS);
		`CHK(rdat, 32'h4)
		`CHK(pin_oe_o, 1'b0)
		wr(PIN_OFS, 8'h01);
		repeat (3) @(posedge mclk_i);
		`CHK({pin_oe_o, pin_o, level}, 3'b111)
		wr(CTRL_OFS, 8'h80);
		repeat (3) @(posedge mclk_i);
		`CHK(pin_o, 1'b0)
		rd(PIN_OFS);
		`CHK(rdat, 32'h5)
		$display("test preset done");
		wr(COMPARE_OFS, 8'hF8);
		wr(COUNT_OFS, 8'hF0);
		wr(CTRL_OFS, 8'h10);
		repeat (40) @(posedge mclk_i);
		wr(CTRL_OFS, 8'h00);
		rd(STATUS_OFS);
		`CHK(rdat, 32'h3)
		rd(COUNT_OFS);
		`CHK(rdat < 32'h40, 1'b1)
		wr(STATUS_OFS, 8'h03);
		rd(STATUS_OFS);
		`CHK(rdat, 32'h0)
		$display("test normal done");
		for (int cs = 1; cs < 4; cs++) begin
			c = $unsigned($random(seed)) % 8;
			wr(CTRL_OFS, 8'h00);
			wr(COMPARE_OFS, c[7:0]);
			// a count write blocks the next match; starting at max keeps
			// a zero compare from waiting a whole wrap
			wr(COUNT_OFS, 8'hFF);
			wr(CTRL_OFS, {1'b0, cs[2:0], COM_TOGGLE, MODE_CTC});
			hp = nfac[cs] * (c + 1);
			repeat (4 * hp + 20) @(posedge mclk_i);
			`CHK(hi_len, hp)
			`CHK(lo_len, hp)
			rd(STATUS_OFS);
			`CHK(rdat[1], 1'b1)
			`CHK(rdat[0], 1'b1)
			wr(STATUS_OFS, 8'h03);
		end
		$display("test clear on match done");
		for (int pol = 0; pol < 2; pol++) begin
			c = $unsigned($random(seed)) % 200;
			wr(CTRL_OFS, 8'h00);
			wr(COUNT_OFS, 8'h00);
			wr(CTRL_OFS, pol ? 8'h1F : 8'h1B);
			// written while running: held in the buffer until max
			wr(COMPARE_OFS, c[7:0]);
			rd(COMPARE_OFS);
			`CHK(rdat, c)
			repeat (600) @(posedge mclk_i);
			`CHK(hi_len, pol ? 255 - c : c + 1)
			`CHK(lo_len, pol ? c + 1 : 255 - c)
			rd(STATUS_OFS);
			`CHK(rdat[0], 1'b1)
			wr(STATUS_OFS, 8'h03);
		end
		$display("test fast pwm done");
		report_and_stop();
	end
endmodule : test_timer_waveform_output_modes
